// ==== logic/odsc_map.vh ====
// constants of the octal driver serial control block
// assumes a 200 MHz system clock sampling the serial pins
`ifndef ODSC_MAP_VH
`define ODSC_MAP_VH

// system clock rate in MHz
`define ODSC_CLK_MHZ         200
// post-update delay in microseconds
`define ODSC_UPDATE_DELAY_US 100
// width of the post-update delay counter
`define ODSC_TIMER_W         15
// shift register and latch width, top bit index
`define ODSC_WIDTH           8
`define ODSC_MSB             7
// output latches reset to all drivers off
`define ODSC_LATCH_RESET     8'hff
// depth and pointer width of the update log buffer
`define ODSC_LOG_DEPTH       8
`define ODSC_LOG_AW          3

`endif

// ==== logic/odsc_sync.v ====
// three-stage input synchroniser with an agreement filter
// assumes din is asynchronous to clk; dout follows once stages 2 and 3 agree
`timescale 1ns/1ps
module odsc_sync #(
  parameter         WIDTH = 1,
  parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
  input  wire             clk,     // system clock
  input  wire             reset_n, // synchronous reset, active low
  input  wire [WIDTH-1:0] din,     // asynchronous input
  output wire [WIDTH-1:0] dout     // filtered level
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  reg [WIDTH-1:0] lvl_q;
  integer         i;

  // stage chain; stage 1 feeds stage 2 only
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      s1_q  <= INIT;
      s2_q  <= INIT;
      s3_q  <= INIT;
      lvl_q <= INIT;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < WIDTH; i = i + 1)
        if (s2_q[i] == s3_q[i])
          lvl_q[i] <= s3_q[i]; // change counts when stages agree
    end
  end

  assign dout = lvl_q;

endmodule

// ==== logic/odsc_fifo.v ====
// synchronous fifo with valid/ready on both sides
// assumes one clock; full stalls the writer, empty stalls the reader
`timescale 1ns/1ps
module odsc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,       // system clock
  input  wire             reset_n,   // synchronous reset, active low
  input  wire             in_valid,  // writer offers a word
  output wire             in_ready,  // space available
  input  wire [WIDTH-1:0] in_data,   // word to store
  output wire             out_valid, // word available
  input  wire             out_ready, // reader takes the word
  output wire [WIDTH-1:0] out_data   // oldest word
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  // honest full and empty from the occupancy count
  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_q];

  // storage array, written only on an accepted push
  always @(posedge clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end

  // pointers and count
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      if (push & ~pop)
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule

// ==== logic/odsc_top.v ====
// serial control and diagnostic logic of an eight-channel low-side switch
// assumes serial pins and comparator outputs are asynchronous to clk and
// that the serial clock is much slower than clk
//
// Behaviour
// - enable fall loads comparator states into shifter
// - serial out updates on each shift clock rise
// - serial in shifted on clock fall while enabled
// - enable rise copies shifter into output latches
// - shifter passes any number of bits through
// - shift clock ignored while enable is high
// - enable rise starts 100 us post-update timer
// - timer running blocks fault clearing of latches
// - after delay, saturated-out active outputs latch off
`timescale 1ns/1ps
`include "odsc_map.vh"
module odsc_top #(
  parameter [`ODSC_TIMER_W-1:0] UPDATE_DELAY_CYC =
    `ODSC_UPDATE_DELAY_US * `ODSC_CLK_MHZ // post-update delay in cycles
) (
  input  wire                clk,                // 200 MHz system clock
  input  wire                reset_n,            // sync reset, active low
  input  wire                serial_io_enable_n, // select pin, active low
  input  wire                sclk,               // shift clock pin
  input  wire                si,                 // serial data in pin
  input  wire [`ODSC_MSB:0]  sat_comp,           // high: above threshold
  output wire                so_o,               // serial data out level
  output wire                so_oe_n,            // low while so_o drives
  output wire [`ODSC_MSB:0]  driver_output_n,    // 1 = driver off
  output wire                unlatch_armed,      // fault clearing allowed
  output wire                fault_unlatch,      // pulse: latch cleared
  output wire                log_valid,          // update log word ready
  input  wire                log_ready,          // update log consumer
  output wire [`ODSC_MSB:0]  log_data,           // latched control byte
  output wire                log_in_ready,       // log has room
  output wire                log_drop            // pulse: update not logged
);

  // controller states, one-hot
  localparam [2:0] ST_MON = 3'b001; // deselected, fault clearing armed
  localparam [2:0] ST_SEL = 3'b010; // selected, shifting
  localparam [2:0] ST_DLY = 3'b100; // deselected, post-update delay

  // edge of a filtered level: pol 1 finds rising, pol 0 falling
  function edge_of;
    input prev;
    input cur;
    input pol;
    begin
      edge_of = (prev != cur) & (cur == pol);
    end
  endfunction

  wire               serial_io_enable_n_f;
  wire               sclk_f;
  wire               si_f;
  wire [`ODSC_MSB:0] comp_f;
  reg                serial_io_enable_n_p_q;
  reg                sclk_p_q;
  wire               serial_io_enable_n_fall;
  wire               serial_io_enable_n_rise;
  wire               sclk_rise;
  wire               sclk_fall;
  reg  [2:0]         state_q;
  reg  [2:0]         state_d;
  reg  [`ODSC_TIMER_W-1:0] tmr_q;
  reg  [`ODSC_TIMER_W-1:0] tmr_d;
  reg  [`ODSC_MSB:0] sr_q;
  reg  [`ODSC_MSB:0] sr_d;
  reg                so_q;
  reg                so_d;
  reg  [`ODSC_MSB:0] latch_q;
  reg  [`ODSC_MSB:0] latch_d;
  reg                unl_q;
  reg                unl_d;
  reg                drop_q;
  wire [`ODSC_MSB:0] trip;
  wire               fifo_in_ready;

  // serial pins through three-stage filters; select idles high
  odsc_sync #(
    .WIDTH (1),
    .INIT  (1'b1)
  ) u_sync_serial_io_enable_n (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (serial_io_enable_n),
    .dout    (serial_io_enable_n_f)
  );

  odsc_sync #(
    .WIDTH (2),
    .INIT  (2'b00)
  ) u_sync_ser (
    .clk     (clk),
    .reset_n (reset_n),
    .din     ({sclk, si}),
    .dout    ({sclk_f, si_f})
  );

  // comparator outputs come from the analog side, also asynchronous
  odsc_sync #(
    .WIDTH (`ODSC_WIDTH),
    .INIT  ({`ODSC_WIDTH{1'b0}})
  ) u_sync_comp (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (sat_comp),
    .dout    (comp_f)
  );

  // previous filtered levels for edge finding
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      serial_io_enable_n_p_q <= 1'b1;
      sclk_p_q <= 1'b0;
    end
    else
    begin
      serial_io_enable_n_p_q <= serial_io_enable_n_f;
      sclk_p_q <= sclk_f;
    end
  end

  // select edges, and shift clock edges gated by the select
  assign serial_io_enable_n_fall = edge_of(serial_io_enable_n_p_q, serial_io_enable_n_f, 1'b0);
  assign serial_io_enable_n_rise = edge_of(serial_io_enable_n_p_q, serial_io_enable_n_f, 1'b1);
  assign sclk_rise = edge_of(sclk_p_q, sclk_f, 1'b1) & ~serial_io_enable_n_f;
  assign sclk_fall = edge_of(sclk_p_q, sclk_f, 1'b0) & ~serial_io_enable_n_f;

  // state sequencing and post-update delay counter
  always @*
  begin
    state_d = state_q;
    tmr_d   = tmr_q;
    case (state_q)
      ST_MON:
      begin
        if (!serial_io_enable_n_f)
          state_d = ST_SEL;
      end
      ST_SEL:
      begin
        if (serial_io_enable_n_rise)
        begin
          state_d = ST_DLY;
          tmr_d   = UPDATE_DELAY_CYC - 1'b1;
        end
      end
      ST_DLY:
      begin
        if (!serial_io_enable_n_f)
          state_d = ST_SEL;                   // reselect during delay
        else if (tmr_q == {`ODSC_TIMER_W{1'b0}})
          state_d = ST_MON;
        else
          tmr_d = tmr_q - 1'b1;
      end
      default:
      begin
        state_d = ST_DLY;
        tmr_d   = UPDATE_DELAY_CYC - 1'b1;
      end
    endcase
  end

  // outputs that are active and sit above the saturation threshold
  assign trip = comp_f & ~latch_q;

  // shift register, serial out stage and output latches
  always @*
  begin
    sr_d    = sr_q;
    so_d    = so_q;
    latch_d = latch_q;
    unl_d   = 1'b0;
    if (serial_io_enable_n_fall)
    begin
      sr_d = comp_f;
      so_d = comp_f[`ODSC_MSB];          // first status bit ready early
    end
    else
    begin
      if (sclk_rise)
        so_d = sr_q[`ODSC_MSB];
      if (sclk_fall)
        sr_d = {sr_q[`ODSC_MSB-1:0], si_f};
    end
    if (serial_io_enable_n_rise)
      latch_d = sr_q;
    else if ((state_q == ST_MON) && serial_io_enable_n_f && (trip != 8'h00))
    begin
      latch_d = latch_q | trip;
      unl_d   = 1'b1;
    end
  end

  // register stage
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q <= ST_MON;
      tmr_q   <= {`ODSC_TIMER_W{1'b0}};
      sr_q    <= {`ODSC_WIDTH{1'b0}};
      so_q    <= 1'b0;
      latch_q <= `ODSC_LATCH_RESET;
      unl_q   <= 1'b0;
      drop_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
      sr_q    <= sr_d;
      so_q    <= so_d;
      latch_q <= latch_d;
      unl_q   <= unl_d;
      drop_q  <= serial_io_enable_n_rise & ~fifo_in_ready; // log full at update
    end
  end

  // log of each byte committed to the latches while the log has room
  odsc_fifo #(
    .WIDTH (`ODSC_WIDTH),
    .DEPTH (`ODSC_LOG_DEPTH),
    .AW    (`ODSC_LOG_AW)
  ) u_log (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (serial_io_enable_n_rise),
    .in_ready  (fifo_in_ready),
    .in_data   (sr_q),
    .out_valid (log_valid),
    .out_ready (log_ready),
    .out_data  (log_data)
  );

  // pin and status outputs
  assign so_o            = so_q;
  assign so_oe_n         = serial_io_enable_n_f;
  assign driver_output_n = latch_q;
  assign unlatch_armed   = (state_q == ST_MON);
  assign fault_unlatch   = unl_q;
  assign log_in_ready    = fifo_in_ready;
  assign log_drop        = drop_q;

endmodule

// ==== tb/odsc_top_sva.sv ====
// checker for the serial control block, bound to its top module
// assumes only the top-level ports are visible
`timescale 1ns/1ps
`include "odsc_map.vh"
module odsc_top_sva #(
  parameter [`ODSC_TIMER_W-1:0] UPDATE_DELAY_CYC = 20000
) (
  input wire               clk,                // system clock
  input wire               reset_n,            // sync reset
  input wire               serial_io_enable_n, // select pin
  input wire [`ODSC_MSB:0] sat_comp,           // comparators
  input wire               so_oe_n,            // serial out enable
  input wire [`ODSC_MSB:0] driver_output_n,    // output latches
  input wire               unlatch_armed,      // clearing allowed
  input wire               fault_unlatch,      // latch cleared
  input wire               log_drop            // update not logged
);
  logic [15:0] wait_q; // cycles spent disarmed

  // count deselected, disarmed cycles to time the post-update delay;
  // the frame itself is not part of the delay, so selection clears it
  always_ff @(posedge clk)
  begin
    if (!reset_n || unlatch_armed || !so_oe_n)
      wait_q <= 16'h0000;
    else
      wait_q <= wait_q + 16'h0001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  out_idle_a: assert property (serial_io_enable_n [*8] |-> so_oe_n)
    else $error("serial out driven while deselected");
  out_drive_a: assert property (!serial_io_enable_n [*8] |-> !so_oe_n)
    else $error("serial out idle while selected");
  latch_hold_a: assert property (!so_oe_n && !$past(so_oe_n)
    |-> $stable(driver_output_n))
    else $error("latches moved while selected");
  fault_gate_a: assert property (fault_unlatch |-> $past(unlatch_armed))
    else $error("fault clearing during delay");
  fault_bits_a: assert property (fault_unlatch |-> driver_output_n !=
    $past(driver_output_n) && ($past(driver_output_n) & ~driver_output_n) == 0)
    else $error("fault clear did not only switch outputs off");
  stale_fault_a: assert property ((unlatch_armed &&
    |(sat_comp & ~driver_output_n)) [*8] |-> 1'b0)
    else $error("saturated active output left on");
  delay_len_a: assert property ($rose(unlatch_armed) |->
    $past(wait_q) >= UPDATE_DELAY_CYC - 1 &&
    $past(wait_q) <= UPDATE_DELAY_CYC + 2)
    else $error("post-update delay of wrong length");
  arm_drop_a: assert property ($rose(so_oe_n) |-> ##[0:3] !unlatch_armed)
    else $error("update did not start the delay");

  cover property (fault_unlatch);
  cover property ($rose(unlatch_armed));
  cover property (log_drop);
endmodule

bind odsc_top odsc_top_sva #(.UPDATE_DELAY_CYC(UPDATE_DELAY_CYC)) u_sva (
  .clk(clk), .reset_n(reset_n), .serial_io_enable_n(serial_io_enable_n),
  .sat_comp(sat_comp), .so_oe_n(so_oe_n), .driver_output_n(driver_output_n),
  .unlatch_armed(unlatch_armed), .fault_unlatch(fault_unlatch),
  .log_drop(log_drop));

// ==== tb/odsc_host.sv ====
// host model driving the serial link with a 48 ns shift clock
// assumes the device samples the pins with its own faster clock
`timescale 1ns/1ps
module odsc_host (
  output logic serial_io_enable_n, // select, active low
  output logic sclk,               // shift clock
  output logic si,                 // serial data to device
  input  wire  so_o,               // serial data from device
  input  wire  so_oe_n             // low while device drives
);
  // idle link: deselected, clock low
  initial
  begin
    serial_io_enable_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // one frame of n bits, msb first; status gathered in arrival order
  task automatic xfer(input logic [15:0] d, input int n,
                      output logic [15:0] st);
    st = 16'h0000;
    #3 serial_io_enable_n = 1'b0;
    #100;
    for (int i = n - 1; i >= 0; i--)
    begin
      si = d[i];
      #12 sclk = 1'b1;
      #24 sclk = 1'b0;
      #12 st = {st[14:0], so_oe_n ? 1'bx : so_o};
    end
    #100 serial_io_enable_n = 1'b1;
    si = ~si; // data line no longer meaningful
  endtask

  // shift clock pulses with the device deselected
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  endtask
endmodule

// ==== tb/tb.sv ====
// bench for the serial control block: table of frames, then edge cases
// assumes the host model drives the link pins
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, reset_n = 1'b0, log_ready = 1'b0;
  logic [7:0]  sat_comp = 8'h00;
  wire         sel_n, sclk, si, so_o, so_oe_n, armed, fu, lv, lir, ldrop;
  wire  [7:0]  drv, ldata;
  int          mismatches = 0, checked = 0, cyc = 0;
  logic        drop_seen = 1'b0;
  // control byte over comparator states
  logic [15:0] rows [8] = '{16'h0000, 16'hffff, 16'h5a81, 16'ha53c,
                            16'h0ff0, 16'h8001, 16'h7e7e, 16'h3344};

  odsc_host u_host (.serial_io_enable_n(sel_n), .sclk(sclk), .si(si),
    .so_o(so_o), .so_oe_n(so_oe_n));
  odsc_top #(.UPDATE_DELAY_CYC(15'd50)) u_dut (.clk(clk), .reset_n(reset_n),
    .serial_io_enable_n(sel_n), .sclk(sclk), .si(si), .sat_comp(sat_comp),
    .so_o(so_o), .so_oe_n(so_oe_n), .driver_output_n(drv),
    .unlatch_armed(armed), .fault_unlatch(fu), .log_valid(lv),
    .log_ready(log_ready), .log_data(ldata), .log_in_ready(lir),
    .log_drop(ldrop));

  // 200 MHz clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // sticky record of dropped log entries, sampled away from the launch edge
  always @(negedge clk)
  begin
    if (ldrop === 1'b1)
      drop_seen = 1'b1;
  end

  // hang limit
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [15:0] exp, got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one frame, then the latches inside and after the delay
  task automatic run(input logic [15:0] d, input int n,
                     input logic [7:0] comp);
    logic [15:0] st;
    @(posedge clk) sat_comp <= comp;
    repeat (8) @(posedge clk);
    u_host.xfer(d, n, st);
    chk("status", n == 8 ? {8'h00, comp} : {comp, d[15:8]}, st);
    repeat (12) @(posedge clk);
    #1;
    chk("latch", {8'h00, d[7:0]}, {8'h00, drv});
    chk("armed", 16'h0000, {15'h0000, armed});
    for (int i = 0; i < 100 && armed !== 1'b1; i++)
      @(posedge clk);
    repeat (10) @(posedge clk);
    #1;
    chk("cleared", {8'h00, d[7:0] | comp}, {8'h00, drv});
    $display("frame %h of %0d bits done", d, n);
  endtask

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk("reset latch", 16'h00ff, {8'h00, drv});
    foreach (rows[i])
      run({8'h00, rows[i][15:8]}, 8, rows[i][7:0]);
    chk("log room", 16'h0000, {15'h0000, lir});
    run(16'hc396, 16, 8'h00);
    chk("log drop", 16'h0001, {15'h0000, drop_seen});
    for (int i = 0; i < 8; i++)
    begin
      chk("log word", {8'h01, rows[i][15:8]}, {7'h00, lv, ldata});
      @(posedge clk) log_ready <= 1'b1;
      @(posedge clk) log_ready <= 1'b0;
      #1;
    end
    chk("log empty", 16'h0000, {15'h0000, lv});
    $display("log test done");
    u_host.idle_clocks(8);
    repeat (12) @(posedge clk);
    #1;
    chk("ignored clock", 16'h0196, {7'h00, so_oe_n, drv});
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("reset", 16'h01ff, {7'h00, so_oe_n, drv});
    @(posedge clk) reset_n <= 1'b1;
    $display("reset test done");
    close_out();
  end
endmodule
